// ===== pkg/tssc_pkg.sv
// Shared constants and types for the two-speed start-up and fail-safe clock supervisor.
package tssc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int OST_COUNT = 1024;
  localparam int LF_DIV = 64;
  localparam int PWRUP_TIME_US = 64;
  localparam int PWRUP_CYCLES = PWRUP_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_OSC_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_OSC_TUNE = 8'h08;
  localparam logic [7:0] OFS_IRQ_FLAGS2 = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN2 = 8'h10;
  localparam logic [7:0] OFS_IRQ_PRIO2 = 8'h14;
  localparam logic [7:0] OFS_INT_GLOBAL = 8'h18;
  localparam logic [7:0] OFS_CFG_OSC_HI = 8'h1C;
  localparam logic [7:0] OFS_CFG_BOR_LO = 8'h20;
  localparam logic [7:0] OFS_CFG_PIN_HI = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int OC_IDLE_BIT = 7;
  localparam int OC_DONE_BIT = 3;
  localparam int OC_SCS_UP_BIT = 1;
  localparam logic [7:0] OC_RW_MASK = 8'hF3;
  localparam logic [7:0] OC2_RW_MASK = 8'h1C;
  localparam int OSCF_BIT = 7;
  localparam int TWO_SPEED_ENABLE_BIT = 7;
  localparam int FAIL_MONITOR_ENABLE_BIT = 6;
  localparam int POWER_UP_DELAY_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OC_RST = 8'h30;
  localparam logic [7:0] REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Primary oscillator configuration codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FOSC_LP = 4'h0;
  localparam logic [3:0] FOSC_XT = 4'h1;
  localparam logic [3:0] FOSC_HS_HI = 4'h2;
  localparam logic [3:0] FOSC_HS_MED = 4'h3;
  localparam logic [3:0] FOSC_INT_A = 4'h8;
  localparam logic [3:0] FOSC_INT_B = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} tssc_src_e;
  typedef enum logic [1:0] {SU_PWRUP, SU_COUNT, SU_RUN, SU_SLEEP} tssc_su_e;
  typedef enum logic [2:0] {SW_IDLE, SW_OLD, SW_HOLD, SW_NEW, SW_REL} tssc_sw_e;

endpackage

// ===== core/tssc_clock_supervisor.sv
// Clock supervisor: start-up timer, two-speed start-up, fail-safe monitor, clock switch.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (RQ1) Crystal modes hold execution for 1024 cycles
// (RQ2) Two-speed needs enable, select 00, crystal
// (RQ3) Two-speed after power-up delay or wake
// (RQ4) Run internal clock while timer counts
// (RQ5) Count done sets status, then switch
// (RQ6) Sleep aborts count, status stays clear
// (RQ7) Status zero until running from external
// (RQ8) Monitor enabled by bit, after timer expiry
// (RQ9) Sample clock is slow oscillator over 64
// (RQ10) Latch set external fall, cleared sample rise
// (RQ11) Fail when sample half-period lacks low
// (RQ12) Failure selects internal, sets fail flag
// (RQ13) Fail flag interrupts only when enabled
// (RQ14) Never return automatically to failed clock
// (RQ15) Fallback frequency from internal select field
// (RQ16) Reset or upper toggle restarts timer
// (RQ17) Flag clears independently of fail condition
// (RQ18) External clock modes skip the timer
// (RQ19) Firmware checks status after start-up
// (RQ20) Firmware enables two-speed with monitor
// (RQ21) Idle bit and source select field
// (RQ22) Select codes primary, secondary, internal
// (RQ23) Glitch-free switch edge sequence
// (RQ24) Detector inputs synchronised before use
// (RQ25) Fail flag sticky until written zero
module tssc_clock_supervisor
  import tssc_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CYCLES,
  parameter int OST_CYC = OST_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] cfg_osc_high,
  input wire logic [7:0] cfg_brownout_low,
  input wire logic [7:0] cfg_pin_high,
  input wire logic ext_osc_in,
  input wire logic sec_osc_in,
  input wire logic int_osc_in,
  input wire logic slow_osc_in,
  input wire logic [2:0] osc_stable_in,
  input wire logic sleep_req,
  input wire logic wake_req,
  output logic [1:0] clk_src_sel,
  output logic clk_hold,
  output logic [2:0] int_freq_sel,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic exec_hold,
  output logic fail_safe_active,
  output logic osc_fail_irq
);

  localparam int PW_W = $clog2(PWRUP_CYC + 1);
  localparam int OST_W = $clog2(OST_CYC + 1);
  localparam int DIV_W = $clog2(LF_DIV);
  localparam int CH_PRI = 0;
  localparam int CH_SLOW = 3;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] osc_raw;
  logic [3:0] osc_s1_reg;
  logic [3:0] osc_s2_reg;
  logic [3:0] osc_s3_reg;
  logic [3:0] osc_rise;
  logic [3:0] osc_fall;
  logic [2:0] stab_s1_reg;
  logic [2:0] stab_s2_reg;

  assign osc_raw = {slow_osc_in, int_osc_in, sec_osc_in, ext_osc_in};

  // Oscillators are sampled, so each must run well below half of ref_clk.
  for (genvar g = 0; g < 4; g++) begin : g_osc_sync
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        osc_s1_reg[g] <= 1'b0;
        osc_s2_reg[g] <= 1'b0;
        osc_s3_reg[g] <= 1'b0;
      end else begin
        osc_s1_reg[g] <= osc_raw[g]; // RQ24
        osc_s2_reg[g] <= osc_s1_reg[g];
        osc_s3_reg[g] <= osc_s2_reg[g];
      end
    end
    assign osc_rise[g] = osc_s2_reg[g] & ~osc_s3_reg[g];
    assign osc_fall[g] = ~osc_s2_reg[g] & osc_s3_reg[g];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stab_s1_reg <= 3'h0;
      stab_s2_reg <= 3'h0;
    end else begin
      stab_s1_reg <= osc_stable_in;
      stab_s2_reg <= stab_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers and configuration decode
  // ----------------------------------------------------------------
  logic [7:0] oc_reg;
  logic [7:0] oc2_reg;
  logic [7:0] tune_reg;
  logic [7:0] pir_reg;
  logic [7:0] pie_reg;
  logic [7:0] ipr_reg;
  logic [7:0] interrupt_global_control_reg;
  logic done_reg;
  logic fail_safe_reg;
  logic idle_reg;
  logic [1:0] scs;
  logic [3:0] fosc;
  logic crystal;
  logic external;
  logic two_speed;
  logic power_up_delay_timer_en;
  logic wr_en;
  logic wr_oc;
  logic scs_tog;
  logic sleep_enter;

  assign scs = oc_reg[1:0];
  assign fosc = cfg_osc_high[3:0];
  assign crystal = (fosc == FOSC_LP) || (fosc == FOSC_XT) ||
                   (fosc == FOSC_HS_HI) || (fosc == FOSC_HS_MED);
  assign external = (fosc != FOSC_INT_A) && (fosc != FOSC_INT_B);
  assign two_speed = cfg_osc_high[TWO_SPEED_ENABLE_BIT] && (scs == 2'b00) && crystal; // RQ2
  assign power_up_delay_timer_en = ~cfg_brownout_low[POWER_UP_DELAY_ENABLE_BIT];
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign wr_oc = wr_en && (paddr == OFS_OSC_CTRL);
  assign scs_tog = wr_oc && (pwdata[OC_SCS_UP_BIT] != scs[1]);
  assign sleep_enter = sleep_req && !oc_reg[OC_IDLE_BIT]; // RQ21

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  tssc_su_e su_reg;
  logic [PW_W-1:0] pwr_cnt_reg;
  logic [OST_W-1:0] ost_cnt_reg;
  logic ost_done;

  assign ost_done = (su_reg == SU_COUNT) && osc_fall[CH_PRI] && !sleep_enter &&
                    !scs_tog && (ost_cnt_reg == OST_W'(OST_CYC - 1)); // RQ1

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      su_reg <= SU_PWRUP;
    end else begin
      case (su_reg)
        SU_PWRUP: begin
          if (!power_up_delay_timer_en || pwr_cnt_reg == PW_W'(PWRUP_CYC - 1)) begin
            su_reg <= crystal ? SU_COUNT : SU_RUN; // RQ3 RQ18
          end
        end
        SU_COUNT: begin
          if (sleep_enter) begin
            su_reg <= SU_SLEEP; // RQ6
          end else if (ost_done) begin
            su_reg <= SU_RUN; // RQ5
          end
        end
        SU_RUN: begin
          if (sleep_enter) begin
            su_reg <= SU_SLEEP;
          end else if (scs_tog && crystal) begin
            su_reg <= SU_COUNT; // RQ16
          end
        end
        SU_SLEEP: begin
          if (wake_req) begin
            su_reg <= crystal ? SU_COUNT : SU_RUN; // RQ3 RQ18
          end
        end
        default: su_reg <= SU_PWRUP;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || su_reg != SU_PWRUP) begin
      pwr_cnt_reg <= '0;
    end else begin
      pwr_cnt_reg <= pwr_cnt_reg + PW_W'(1);
    end
  end

  // A toggle of the upper select bit starts the count over from zero.
  always_ff @(posedge ref_clk) begin
    if (rst || su_reg != SU_COUNT || scs_tog) begin
      ost_cnt_reg <= '0; // RQ16
    end else if (osc_fall[CH_PRI]) begin
      ost_cnt_reg <= ost_cnt_reg + OST_W'(1); // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Fail-safe monitor
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;
  logic smp_rise;
  logic smp_fall;
  logic latch_reg;
  logic mon_active;
  logic fail_det;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg <= '0;
    end else if (osc_rise[CH_SLOW]) begin
      div_reg <= div_reg + DIV_W'(1); // RQ9
    end
  end

  assign smp_rise = osc_rise[CH_SLOW] && (div_reg == DIV_W'(LF_DIV / 2 - 1)); // RQ9
  assign smp_fall = osc_rise[CH_SLOW] && (div_reg == DIV_W'(LF_DIV - 1));

  // Setting wins so an edge coinciding with the clear is not lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latch_reg <= 1'b0;
    end else if (osc_fall[CH_PRI]) begin
      latch_reg <= 1'b1; // RQ10
    end else if (smp_rise) begin
      latch_reg <= 1'b0; // RQ10
    end
  end

  assign mon_active = cfg_osc_high[FAIL_MONITOR_ENABLE_BIT] && (su_reg == SU_RUN) && external &&
                      (scs == 2'b00) && !fail_safe_reg; // RQ8 RQ18
  assign fail_det = mon_active && smp_fall && !latch_reg; // RQ11

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fail_safe_reg <= 1'b0;
    end else if (fail_det) begin
      fail_safe_reg <= 1'b1; // RQ12 RQ14
    end else if (ost_done || (scs_tog && !crystal)) begin
      fail_safe_reg <= 1'b0; // RQ16
    end
  end

  // ----------------------------------------------------------------
  // Source choice and clock enables
  // ----------------------------------------------------------------
  tssc_src_e src_want;
  logic pri_ready;
  logic new_ready;
  logic hold_cond;

  assign pri_ready = (su_reg == SU_RUN);

  always_comb begin
    src_want = SRC_PRI; // RQ22
    if (scs[1]) begin
      src_want = SRC_INT; // RQ21 RQ22
    end else if (scs[0]) begin
      src_want = SRC_SEC; // RQ22
    end else if (fail_safe_reg) begin
      src_want = SRC_INT; // RQ12 RQ14 RQ15
    end else if (!pri_ready && two_speed) begin
      src_want = SRC_INT; // RQ4
    end
  end

  assign new_ready = (src_want != SRC_PRI) || pri_ready;
  assign hold_cond = (su_reg == SU_PWRUP) || (su_reg == SU_SLEEP) ||
                     (src_want == SRC_PRI && !pri_ready); // RQ1

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      idle_reg <= 1'b0;
    end else if (sleep_req && oc_reg[OC_IDLE_BIT]) begin
      idle_reg <= 1'b1; // RQ21
    end else if (wake_req) begin
      idle_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      exec_hold <= 1'b1;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      exec_hold <= hold_cond;
      cpu_clk_en <= !hold_cond && !idle_reg; // RQ21
      periph_clk_en <= (su_reg != SU_PWRUP) && (su_reg != SU_SLEEP);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= pri_ready && external && !fail_safe_reg && (scs == 2'b00); // RQ5 RQ6 RQ7
    end
  end

  // ----------------------------------------------------------------
  // Glitch-free switch sequencer
  // ----------------------------------------------------------------
  tssc_sw_e sw_reg;
  tssc_src_e cur_reg;
  tssc_src_e tgt_reg;
  logic sw_cnt_reg;

  // Internal clock is the source through reset and power-up delay.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_reg <= SW_IDLE;
      cur_reg <= SRC_INT;
      tgt_reg <= SRC_INT;
      sw_cnt_reg <= 1'b0;
      clk_hold <= 1'b0;
    end else begin
      case (sw_reg)
        SW_IDLE: begin
          sw_cnt_reg <= 1'b0;
          if (src_want != cur_reg && new_ready) begin
            tgt_reg <= src_want;
            // A failed clock gives no edges to wait for, so hold at once.
            if (fail_safe_reg && cur_reg == SRC_PRI) begin
              clk_hold <= 1'b1;
              sw_reg <= SW_NEW;
            end else begin
              sw_reg <= SW_OLD;
            end
          end
        end
        SW_OLD: begin
          if (osc_rise[cur_reg]) begin
            sw_cnt_reg <= 1'b1;
            if (sw_cnt_reg) begin
              sw_reg <= SW_HOLD; // RQ23
            end
          end
        end
        SW_HOLD: begin
          sw_cnt_reg <= 1'b0;
          if (osc_fall[cur_reg]) begin
            clk_hold <= 1'b1; // RQ23
            sw_reg <= SW_NEW;
          end
        end
        SW_NEW: begin
          if (osc_rise[tgt_reg]) begin
            sw_cnt_reg <= 1'b1;
            if (sw_cnt_reg) begin
              sw_reg <= SW_REL; // RQ23
            end
          end
        end
        SW_REL: begin
          if (osc_fall[tgt_reg]) begin
            clk_hold <= 1'b0; // RQ23
            cur_reg <= tgt_reg; // RQ5
            sw_reg <= SW_IDLE;
          end
        end
        default: sw_reg <= SW_IDLE;
      endcase
    end
  end

  assign clk_src_sel = cur_reg;
  assign int_freq_sel = oc_reg[6:4]; // RQ15
  assign fail_safe_active = fail_safe_reg;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oc_reg <= OC_RST; // RQ22
    end else if (wr_oc) begin
      oc_reg <= pwdata[7:0] & OC_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oc2_reg <= REG_RST;
    end else if (wr_en && paddr == OFS_OSC_CTRL2) begin
      oc2_reg <= pwdata[7:0] & OC2_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tune_reg <= REG_RST;
      pie_reg <= REG_RST;
      ipr_reg <= REG_RST;
      interrupt_global_control_reg <= REG_RST;
    end else if (wr_en) begin
      if (paddr == OFS_OSC_TUNE) begin
        tune_reg <= pwdata[7:0];
      end
      if (paddr == OFS_IRQ_EN2) begin
        pie_reg <= pwdata[7:0];
      end
      if (paddr == OFS_IRQ_PRIO2) begin
        ipr_reg <= pwdata[7:0];
      end
      if (paddr == OFS_INT_GLOBAL) begin
        interrupt_global_control_reg <= pwdata[7:0];
      end
    end
  end

  // The hardware set comes last, so it wins over a clearing write.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pir_reg <= REG_RST;
    end else begin
      if (wr_en && paddr == OFS_IRQ_FLAGS2) begin
        pir_reg <= pwdata[7:0]; // RQ17 RQ25
      end
      if (fail_det) begin
        pir_reg[OSCF_BIT] <= 1'b1; // RQ12 RQ25
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_fail_irq <= 1'b0;
    end else begin
      osc_fail_irq <= pir_reg[OSCF_BIT] & pie_reg[OSCF_BIT]; // RQ13
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [7:0] rd_data;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 8'h00;
    case (paddr)
      OFS_OSC_CTRL: rd_data = {oc_reg[7:4], done_reg, stab_s2_reg[2], oc_reg[1:0]}; // RQ7
      OFS_OSC_CTRL2: rd_data = {1'b0, cur_reg == SRC_SEC, 1'b0, oc2_reg[4:2],
                                stab_s2_reg[1:0]};
      OFS_OSC_TUNE: rd_data = tune_reg;
      OFS_IRQ_FLAGS2: rd_data = pir_reg;
      OFS_IRQ_EN2: rd_data = pie_reg;
      OFS_IRQ_PRIO2: rd_data = ipr_reg;
      OFS_INT_GLOBAL: rd_data = interrupt_global_control_reg;
      OFS_CFG_OSC_HI: rd_data = cfg_osc_high;
      OFS_CFG_BOR_LO: rd_data = cfg_brownout_low;
      OFS_CFG_PIN_HI: rd_data = cfg_pin_high;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_data};
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_hit;

endmodule // tssc_clock_supervisor

`default_nettype wire

// ===== verification/tssc_ext_osc_model.sv
// Behavioural model of the external crystal that drives the primary oscillator pin.
`timescale 1ns/10ps
`default_nettype none
module tssc_ext_osc_model (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [3:0] half,
  output logic osc
);
  logic [3:0] cnt = 4'h0;
  initial osc = 1'b0;
  // A dead crystal stops in mid swing, so the pin rests at its last level; the
  // fail detector has to notice the missing falling edges, not an idle level.
  always @(posedge ref_clk) begin
    if (run) begin
      if (cnt >= half - 4'd1) begin
        cnt <= 4'h0;
        osc <= ~osc;
      end else begin
        cnt <= cnt + 4'd1;
      end
    end
  end
endmodule // tssc_ext_osc_model
`default_nettype wire

// ===== verification/tssc_sup_assertions.sv
// Port-level checks of the clock supervisor, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module tssc_sup_assertions
  import tssc_pkg::*;
#(
  parameter int PWRUP_CYC = 8,
  parameter int OST_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic [1:0] clk_src_sel,
  input wire logic clk_hold,
  input wire logic [2:0] int_freq_sel,
  input wire logic cpu_clk_en,
  input wire logic exec_hold,
  input wire logic fail_safe_active,
  input wire logic osc_fail_irq
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_SETUP_NO_ERR: assert property (psel && !penable |-> !pslverr)
    else $error("error response outside the access phase");
  AST_UNMAPPED_ERR: assert property (psel && penable && paddr > OFS_CFG_PIN_HI |-> pslverr)
    else $error("unmapped access without error response");
  AST_RESET_STATE: assert property (
    $fell(rst) |-> clk_src_sel == 2'd2 && exec_hold && !cpu_clk_en && !fail_safe_active
    && !osc_fail_irq) else $error("wrong state after reset release");
  AST_FREQ_WRITE: assert property (
    psel && penable && pwrite && pstrb[0] && paddr == OFS_OSC_CTRL
    |=> int_freq_sel == $past(pwdata[6:4])) else $error("frequency field not updated");
  AST_IRQ_MASKED: assert property (
    psel && penable && pwrite && pstrb[0] && paddr == OFS_IRQ_EN2 && !pwdata[7]
    |=> ##1 !osc_fail_irq) else $error("interrupt raised while disabled");
  AST_SLEEP_CPU_OFF: assert property (sleep_req |-> ##[1:4] !cpu_clk_en)
    else $error("cpu clock still enabled after sleep");
  AST_HOLD_BOUNDED: assert property ($rose(clk_hold) |-> ##[1:300] !clk_hold)
    else $error("clock hold never released");
  AST_FAIL_TO_INT: assert property (
    $rose(fail_safe_active) |-> ##[0:60] clk_src_sel == 2'd2)
    else $error("no switch to internal clock on failure");
  AST_FAIL_STAYS: assert property (
    fail_safe_active && clk_src_sel == 2'd2 |=> clk_src_sel == 2'd2 || !fail_safe_active)
    else $error("left internal clock while failure stands");
  AST_FAIL_FROM_RUN: assert property (
    $rose(fail_safe_active) |-> $past(clk_src_sel) == 2'd0)
    else $error("failure declared before running on primary");
endmodule // tssc_sup_assertions

bind tssc_clock_supervisor tssc_sup_assertions #(.PWRUP_CYC(PWRUP_CYC), .OST_CYC(OST_CYC))
  i_chk (.*);
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the clock supervisor over APB and the oscillator pins.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tssc_pkg::*;
  localparam int PWRUP_CYC = 8;
  localparam int OST_CYC = 16;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] cfg_osc_high = 8'hC1;
  logic [7:0] cfg_brownout_low = 8'h00;
  logic [7:0] cfg_pin_high = 8'h5A;
  logic ext_osc_in;
  logic sec_osc_in = 1'b0;
  logic int_osc_in = 1'b0;
  logic slow_osc_in = 1'b0;
  logic [2:0] osc_stable_in = 3'b111;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic [1:0] clk_src_sel;
  logic clk_hold;
  logic [2:0] int_freq_sel;
  logic cpu_clk_en;
  logic periph_clk_en;
  logic exec_hold;
  logic fail_safe_active;
  logic osc_fail_irq;
  logic osc_run = 1'b1;
  logic [3:0] osc_half = 4'h3;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  int t0;

  tssc_clock_supervisor #(.PWRUP_CYC(PWRUP_CYC), .OST_CYC(OST_CYC)) i_dut (.*);
  tssc_ext_osc_model i_osc (.ref_clk(ref_clk), .run(osc_run), .half(osc_half),
    .osc(ext_osc_in));

  always #2.5 ref_clk = ~ref_clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The internal and slow oscillators hold each level for several cycles, since the
  // design samples its oscillator pins through three flops.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    int_osc_in <= cyc[2];
    slow_osc_in <= cyc[3];
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only pready or the bench timeout may end this wait; the master accepts any number of wait states.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic pulse(input logic slp);
    @(posedge ref_clk);
    sleep_req <= slp;
    wake_req <= !slp;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic poll_done();
    for (n = 0; n < 200; n++) begin
      apb(1'b0, OFS_OSC_CTRL, 32'h0000_0000);
      if (rd[OC_DONE_BIT] === 1'b1) break;
    end
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t0 = cyc;
    apb(1'b0, OFS_OSC_CTRL, 32'h0000_0000);
    chk("osc_ctrl", 32'h0000_0030, rd & 32'h0000_00FB);
    chk("src_start", 2'd2, clk_src_sel);
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_data", 32'h0000_0000, rd);
    apb(1'b0, OFS_CFG_PIN_HI, 32'h0000_0000);
    chk("cfg_pin", 32'h0000_005A, rd);
    chk("cpu_clk", 1'b1, cpu_clk_en);
    chk("exec_run", 1'b0, exec_hold);
    poll_done();
    chk("status_done", 1'b1, rd[OC_DONE_BIT]);
    chk("count_len", 1'b1, cyc - t0 >= PWRUP_CYC + (OST_CYC - 1) * 6);
    for (n = 0; n < 200 && clk_src_sel !== 2'd0; n++) @(negedge ref_clk);
    chk("src_primary", 2'd0, clk_src_sel);
    chk("hold_off", 1'b0, clk_hold);
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_0050, 4'h0);
    chk("freq_nostrb", 3'b011, int_freq_sel);
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_0050);
    chk("freq_sel", 3'b101, int_freq_sel);
    $display("test startup finished");
    osc_run <= 1'b0;
    for (n = 0; n < 3000 && fail_safe_active !== 1'b1; n++) @(negedge ref_clk);
    chk("fail_active", 1'b1, fail_safe_active);
    for (n = 0; n < 100 && clk_src_sel !== 2'd2; n++) @(negedge ref_clk);
    chk("fail_src", 2'd2, clk_src_sel);
    chk("fail_freq", 3'b101, int_freq_sel);
    apb(1'b0, OFS_IRQ_FLAGS2, 32'h0000_0000);
    chk("fail_flag", 32'h0000_0080, rd);
    chk("irq_masked", 1'b0, osc_fail_irq);
    apb(1'b1, OFS_IRQ_EN2, 32'h0000_0080);
    repeat (2) @(negedge ref_clk);
    chk("irq_on", 1'b1, osc_fail_irq);
    apb(1'b1, OFS_IRQ_EN2, 32'h0000_0000);
    repeat (2) @(negedge ref_clk);
    chk("irq_disabled", 1'b0, osc_fail_irq);
    apb(1'b1, OFS_IRQ_EN2, 32'h0000_0080);
    osc_run <= 1'b1;
    repeat (600) @(negedge ref_clk);
    chk("no_auto_src", 2'd2, clk_src_sel);
    chk("no_auto_fail", 1'b1, fail_safe_active);
    apb(1'b1, OFS_IRQ_FLAGS2, 32'h0000_0000);
    apb(1'b0, OFS_IRQ_FLAGS2, 32'h0000_0000);
    chk("flag_clear", 32'h0000_0000, rd);
    chk("fail_kept", 1'b1, fail_safe_active);
    chk("irq_off", 1'b0, osc_fail_irq);
    $display("test failure finished");
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_0052);
    apb(1'b0, OFS_OSC_CTRL, 32'h0000_0000);
    chk("sel_internal", 32'h0000_0052, rd & 32'h0000_00F3);
    chk("src_internal", 2'd2, clk_src_sel);
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_0050);
    chk("fail_counting", 1'b1, fail_safe_active);
    for (n = 0; n < 400 && fail_safe_active !== 1'b0; n++) @(negedge ref_clk);
    chk("fail_cleared", 1'b0, fail_safe_active);
    for (n = 0; n < 200 && clk_src_sel !== 2'd0; n++) @(negedge ref_clk);
    chk("src_back", 2'd0, clk_src_sel);
    $display("test toggle finished");
    osc_half <= 4'h5;
    pulse(1'b1);
    chk("sleep_cpu", 1'b0, cpu_clk_en);
    chk("sleep_periph", 1'b0, periph_clk_en);
    chk("sleep_hold", 1'b1, exec_hold);
    pulse(1'b0);
    for (n = 0; n < 60 && clk_src_sel !== 2'd2; n++) @(negedge ref_clk);
    chk("wake_src", 2'd2, clk_src_sel);
    pulse(1'b1);
    repeat (300) @(negedge ref_clk);
    apb(1'b0, OFS_OSC_CTRL, 32'h0000_0000);
    chk("abort_status", 1'b0, rd[OC_DONE_BIT]);
    pulse(1'b0);
    poll_done();
    chk("wake_done", 1'b1, rd[OC_DONE_BIT]);
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_00D0);
    pulse(1'b1);
    chk("idle_cpu", 1'b0, cpu_clk_en);
    chk("idle_periph", 1'b1, periph_clk_en);
    pulse(1'b0);
    $display("test sleep finished");
    apb(1'b1, OFS_OSC_CTRL, 32'h0000_0050);
    // An external clock mode skips the start-up count, so the status is up right after wake.
    @(posedge ref_clk);
    cfg_osc_high <= 8'hC4;
    pulse(1'b1);
    pulse(1'b0);
    apb(1'b0, OFS_OSC_CTRL, 32'h0000_0000);
    chk("ext_no_timer", 1'b1, rd[OC_DONE_BIT]);
    $display("test external finished");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
